// [hw/iam_sequencer.sv]
// Acknowledge and stop sequencer of the two-wire master port.
`timescale 1ns/100ps

// How it works
// - Starting an acknowledge pulls SCL low and puts the ack value on SDA.
// - After one baud period of the acknowledge, SCL is released.
// - Once SCL reads high, one more baud period, then SCL goes low.
// - Then the ack enable clears, the generator stops, port is idle.
// - Buffer write during an acknowledge sets collision, buffer unchanged.
// - In master mode, SCL is held low from the ninth clock's falling edge onward.
// - Starting a stop pulls SDA low.
// - With SDA read low, reload, count to zero, then release SCL.
// - One baud period after SCL release, SDA is released.
// - SDA read high while SCL high sets the stop-detected flag.
// - One baud period later the stop enable clears and irq flag sets.
// - Buffer write during a stop sets collision and is discarded.
// - Master mode code 1000 sets bus clock to core over 4*(div+1).
module iam_sequencer
    import iam_pkg::*;
#(
    parameter int DIV_W = 8
)
(
    input  wire logic              CORE_CLK,
    input  wire logic              RST_B,
    input  wire logic              CE,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output      logic [DATA_W-1:0] RDATA,
    input  wire logic              NINTH_FALL,
    input  wire logic              SCL_IN,
    output      logic              SCL_OUT,
    output      logic              SCL_OE_B,
    input  wire logic              SDA_IN,
    output      logic              SDA_OUT,
    output      logic              SDA_OE_B,
    output      logic [DATA_W-1:0] SHIFT_BUFFER
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // The generator is built for an eight-bit divisor.
    if (DIV_W != 8) begin : g_bad_div
        $error("DIV_W must be 8");
    end

    // ****************************************************************
    // Declarations
    // ****************************************************************
    iam_state_t        state_reg;
    iam_state_t        state_next;
    logic [3:0]        port_mode_select_reg;
    logic              ack_data_value_reg;
    logic              ack_seq_enable_reg;
    logic              stop_seq_enable_reg;
    logic              stop_detected_reg;
    logic              write_collision_flag_reg;
    logic              serial_port_irq_flag_reg;
    logic [7:0]        baud_divisor_value_reg;
    logic [7:0]        serial_shift_buffer_reg;
    logic [7:0]        rdata_reg;
    logic              scl_oe_b_reg;
    logic              sda_oe_b_reg;
    logic              scl_out_reg;
    logic              sda_out_reg;
    logic              brg_load;
    logic              brg_run;
    logic              wr_ctl;
    logic              wr_sta;
    logic              wr_buf;
    logic              master_mode;
    logic              start_ack;
    logic              start_stop;
    logic              is_idle;

    iam_baud_if brg ();

    iam_baud_gen u_baud (
        .CORE_CLK (CORE_CLK),
        .RST_B    (RST_B),
        .CE       (CE),
        .brg      (brg.gen)
    );

    assign RDATA        = rdata_reg;
    assign SCL_OE_B     = scl_oe_b_reg;
    assign SDA_OE_B     = sda_oe_b_reg;
    assign SCL_OUT      = scl_out_reg;
    assign SDA_OUT      = sda_out_reg;
    assign SHIFT_BUFFER = serial_shift_buffer_reg;

    // ****************************************************************
    // Decode
    // ****************************************************************
    assign wr_ctl      = WR && (ADDR == OFS_CONTROL);
    assign wr_sta      = WR && (ADDR == OFS_STATUS);
    assign wr_buf      = WR && (ADDR == OFS_BUFFER);
    assign master_mode = (port_mode_select_reg == MODE_I2C_MASTER);
    assign is_idle     = (state_reg == IAM_IDLE);
    // Starts are accepted only from idle; the ack wins if both are set.
    assign start_ack   = wr_ctl && WDATA[CTL_ACK_EN] && master_mode
                         && is_idle;
    assign start_stop  = wr_ctl && WDATA[CTL_STOP_EN] && !WDATA[CTL_ACK_EN]
                         && master_mode && is_idle;

    assign brg.divisor = baud_divisor_value_reg;
    assign brg.load    = brg_load;
    assign brg.run     = brg_run;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        brg_load   = 1'b0;
        brg_run    = 1'b0;
        unique case (state_reg)
            IAM_IDLE: begin
                if (start_ack) begin
                    state_next = IAM_ACK_LOW;
                    brg_load   = 1'b1;
                end else if (start_stop) begin
                    state_next = IAM_STP_SDA;
                end
            end
            IAM_ACK_LOW: begin
                brg_run = 1'b1;
                if (brg.tick) begin
                    state_next = IAM_ACK_WAIT;
                end
            end
            IAM_ACK_WAIT: begin
                if (SCL_IN) begin
                    state_next = IAM_ACK_HIGH;
                    brg_load   = 1'b1;
                end
            end
            IAM_ACK_HIGH: begin
                brg_run = 1'b1;
                if (brg.tick) begin
                    state_next = IAM_IDLE;
                end
            end
            IAM_STP_SDA: begin
                if (!SDA_IN) begin
                    state_next = IAM_STP_SCL;
                    brg_load   = 1'b1;
                end
            end
            IAM_STP_SCL: begin
                brg_run = 1'b1;
                if (brg.tick) begin
                    state_next = IAM_STP_HIGH;
                end
            end
            IAM_STP_HIGH: begin
                brg_run = 1'b1;
                if (brg.tick) begin
                    state_next = IAM_STP_DET;
                end
            end
            IAM_STP_DET: begin
                if (SDA_IN && SCL_IN) begin
                    state_next = IAM_STP_END;
                    brg_load   = 1'b1;
                end
            end
            IAM_STP_END: begin
                brg_run = 1'b1;
                if (brg.tick) begin
                    state_next = IAM_IDLE;
                end
            end
            default: begin
                state_next = IAM_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= IAM_IDLE;
        end else if (CE) begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Bus pins
    // ****************************************************************
    // Both lines are open drain: the output level is always low and only
    // the enable moves, so a released line floats to the pull-up.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            scl_out_reg <= 1'b0;
            sda_out_reg <= 1'b0;
        end else if (CE) begin
            scl_out_reg <= 1'b0;
            sda_out_reg <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            scl_oe_b_reg <= 1'b1;
        end else if (CE) begin
            if (NINTH_FALL && master_mode) begin
                scl_oe_b_reg <= 1'b0;
            end
            unique case (state_next)
                IAM_ACK_LOW, IAM_STP_SDA, IAM_STP_SCL: begin
                    scl_oe_b_reg <= 1'b0;
                end
                IAM_ACK_WAIT, IAM_STP_HIGH, IAM_STP_DET, IAM_STP_END: begin
                    scl_oe_b_reg <= 1'b1;
                end
                IAM_ACK_HIGH: begin
                    if (brg.tick) begin
                        scl_oe_b_reg <= 1'b0;
                    end else begin
                        scl_oe_b_reg <= 1'b1;
                    end
                end
                IAM_IDLE: begin
                    if (state_reg == IAM_ACK_HIGH) begin
                        scl_oe_b_reg <= 1'b0;
                    end
                end
                default: begin
                    scl_oe_b_reg <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sda_oe_b_reg <= 1'b1;
        end else if (CE) begin
            unique case (state_next)
                IAM_ACK_LOW, IAM_ACK_WAIT, IAM_ACK_HIGH: begin
                    sda_oe_b_reg <= start_ack ? WDATA[CTL_ACK_DATA]
                                    : ack_data_value_reg;
                end
                IAM_STP_SDA, IAM_STP_SCL, IAM_STP_HIGH: begin
                    sda_oe_b_reg <= 1'b0;
                end
                default: begin
                    sda_oe_b_reg <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // Software registers
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            port_mode_select_reg   <= MODE_RESET;
            ack_data_value_reg     <= 1'b0;
            baud_divisor_value_reg <= BAUD_RESET;
        end else if (CE) begin
            if (wr_ctl) begin
                port_mode_select_reg <= WDATA[CTL_MODE_LSB +: CTL_MODE_W];
                if (is_idle) begin
                    ack_data_value_reg <= WDATA[CTL_ACK_DATA];
                end
            end
            if (WR && (ADDR == OFS_BAUD)) begin
                baud_divisor_value_reg <= WDATA;
            end
        end
    end

    // Enables only start from idle and are cleared by hardware at the end.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ack_seq_enable_reg  <= 1'b0;
            stop_seq_enable_reg <= 1'b0;
        end else if (CE) begin
            if (start_ack) begin
                ack_seq_enable_reg <= 1'b1;
            end else if (state_reg == IAM_ACK_HIGH && brg.tick) begin
                ack_seq_enable_reg <= 1'b0;
            end
            if (start_stop) begin
                stop_seq_enable_reg <= 1'b1;
            end else if (state_reg == IAM_STP_END && brg.tick) begin
                stop_seq_enable_reg <= 1'b0;
            end
        end
    end

    // Status flags clear on a write of one; a same-cycle set wins.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            stop_detected_reg        <= 1'b0;
            write_collision_flag_reg <= 1'b0;
            serial_port_irq_flag_reg <= 1'b0;
        end else if (CE) begin
            if (state_reg == IAM_STP_DET && SDA_IN && SCL_IN) begin
                stop_detected_reg <= 1'b1;
            end else if (wr_sta && WDATA[STA_STOP_DET]) begin
                stop_detected_reg <= 1'b0;
            end
            if (wr_buf && !is_idle) begin
                write_collision_flag_reg <= 1'b1;
            end else if (wr_sta && WDATA[STA_WRITE_COLLISION_FLAG]) begin
                write_collision_flag_reg <= 1'b0;
            end
            if (state_reg == IAM_STP_END && brg.tick) begin
                serial_port_irq_flag_reg <= 1'b1;
            end else if (wr_sta && WDATA[STA_IRQ]) begin
                serial_port_irq_flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            serial_shift_buffer_reg <= BUFFER_RESET;
        end else if (CE) begin
            if (wr_buf && is_idle) begin
                serial_shift_buffer_reg <= WDATA;
            end
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_reg <= 8'h00;
        end else if (CE) begin
            if (RD) begin
                unique case (ADDR)
                    OFS_CONTROL: begin
                        rdata_reg <= {1'b0, stop_seq_enable_reg,
                                      ack_seq_enable_reg, ack_data_value_reg,
                                      port_mode_select_reg};
                    end
                    OFS_STATUS: begin
                        rdata_reg <= {4'h0, is_idle,
                                      serial_port_irq_flag_reg,
                                      write_collision_flag_reg,
                                      stop_detected_reg};
                    end
                    OFS_BAUD: begin
                        rdata_reg <= baud_divisor_value_reg;
                    end
                    OFS_BUFFER: begin
                        rdata_reg <= serial_shift_buffer_reg;
                    end
                endcase
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end

endmodule

// [hw/iam_pkg.sv]
// Constants and types shared by the acknowledge and stop sequencer.
package iam_pkg;

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam int         DATA_W           = 8;
    localparam int         ADDR_W           = 2;
    localparam logic [1:0] OFS_CONTROL      = 2'h0;
    localparam logic [1:0] OFS_STATUS       = 2'h1;
    localparam logic [1:0] OFS_BAUD         = 2'h2;
    localparam logic [1:0] OFS_BUFFER       = 2'h3;

    localparam int         CTL_MODE_LSB     = 0;
    localparam int         CTL_MODE_W       = 4;
    localparam int         CTL_ACK_DATA     = 4;
    localparam int         CTL_ACK_EN       = 5;
    localparam int         CTL_STOP_EN      = 6;

    localparam int         STA_STOP_DET     = 0;
    localparam int         STA_WRITE_COLLISION_FLAG         = 1;
    localparam int         STA_IRQ          = 2;
    localparam int         STA_IDLE         = 3;

    localparam logic [3:0] MODE_I2C_MASTER  = 4'h8;
    localparam logic [3:0] MODE_RESET       = 4'h0;
    localparam logic [7:0] BAUD_RESET       = 8'h00;
    localparam logic [7:0] BUFFER_RESET     = 8'h00;

    // ****************************************************************
    // Timing
    // ****************************************************************
    // The bus clock is the core clock over 4*(divisor+1); each baud
    // period is half a bus clock, so 2*(divisor+1) core cycles.
    localparam int         BAUD_HALF_FACTOR = 2;

    typedef enum logic [8:0] {
        IAM_IDLE      = 9'h001,
        IAM_ACK_LOW   = 9'h002,
        IAM_ACK_WAIT  = 9'h004,
        IAM_ACK_HIGH  = 9'h008,
        IAM_STP_SDA   = 9'h010,
        IAM_STP_SCL   = 9'h020,
        IAM_STP_HIGH  = 9'h040,
        IAM_STP_DET   = 9'h080,
        IAM_STP_END   = 9'h100
    } iam_state_t;

    // Reload value of the down counter for one baud period.
    function automatic logic [8:0] iam_reload(input logic [7:0] div);
        logic [9:0] full;
        full = 10'(BAUD_HALF_FACTOR) * ({2'h0, div} + 10'h001);
        return 9'(full - 10'h001);
    endfunction

endpackage

// [hw/iam_baud_if.sv]
// Interface between the sequencer and its baud rate generator.
`timescale 1ns/100ps
interface iam_baud_if;
    logic       load;
    logic       run;
    logic [7:0] divisor;
    logic       tick;

    modport ctl (output load, output run, output divisor, input tick);
    modport gen (input load, input run, input divisor, output tick);
endinterface

// [hw/iam_baud_gen.sv]
// Baud rate generator: reloadable down counter with a timeout tick.
`timescale 1ns/100ps
module iam_baud_gen
    import iam_pkg::*;
(
    input  wire logic CORE_CLK,
    input  wire logic RST_B,
    input  wire logic CE,
    iam_baud_if.gen   brg
);

    logic [8:0] count_reg;
    logic       tick_reg;

    assign brg.tick = tick_reg;

    // ****************************************************************
    // Down counter
    // ****************************************************************
    // A load restarts the period, so each tick marks a full period.
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            count_reg <= 9'h000;
            tick_reg  <= 1'b0;
        end else if (CE) begin
            tick_reg <= 1'b0;
            if (brg.load) begin
                count_reg <= iam_reload(brg.divisor);
            end else if (brg.run) begin
                if (count_reg == 9'h000) begin
                    tick_reg  <= 1'b1;
                    count_reg <= iam_reload(brg.divisor);
                end else begin
                    count_reg <= count_reg - 9'h001;
                end
            end
        end
    end

endmodule

// [verif/iam_slave_model.sv]
// Slave side of the two-wire bus: pull-ups and clock stretching.
`timescale 1ns/100ps
module iam_slave_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       scl_oe_b,
    input  wire logic       sda_oe_b,
    input  wire logic [3:0] stretch,
    output      logic       scl_wire,
    output      logic       sda_wire
);
    logic [3:0] hold_reg;

    // A released line floats up to the pull-up level.
    assign sda_wire = sda_oe_b;
    // The slave keeps SCL low for a while after the master lets it go.
    assign scl_wire = scl_oe_b && hold_reg == 4'h0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            hold_reg <= 4'h0;
        else if (!scl_oe_b)
            hold_reg <= stretch;
        else if (hold_reg != 4'h0)
            hold_reg <= hold_reg - 4'h1;
    end
endmodule

// [verif/iam_seq_props.sv]
// Pin-level checker of the acknowledge and stop sequencer.
`timescale 1ns/100ps
module iam_seq_props
    import iam_pkg::*;
(
    input wire logic              CORE_CLK,
    input wire logic              RST_B,
    input wire logic              CE,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic              WR,
    input wire logic              RD,
    input wire logic [DATA_W-1:0] RDATA,
    input wire logic              NINTH_FALL,
    input wire logic              SCL_IN,
    input wire logic              SCL_OUT,
    input wire logic              SCL_OE_B,
    input wire logic              SDA_IN,
    input wire logic              SDA_OUT,
    input wire logic              SDA_OE_B,
    input wire logic [DATA_W-1:0] SHIFT_BUFFER
);
    // ********
    // Shadow of mode, divisor and sequence phase
    // ********
    logic [3:0] mode_reg;
    logic [7:0] div_reg;
    logic [1:0] seq_reg;
    logic       rel_reg;
    logic       go_reg;
    logic [9:0] cnt_reg;
    logic [9:0] tper;
    logic       ctl_wr, ack_go, stp_go, in_ack, in_stp, win;

    assign ctl_wr = CE && WR && ADDR == OFS_CONTROL;
    assign ack_go = ctl_wr && WDATA[CTL_ACK_EN] && seq_reg == 2'h0
                    && mode_reg == MODE_I2C_MASTER;
    assign stp_go = ctl_wr && WDATA[CTL_STOP_EN] && !WDATA[CTL_ACK_EN]
                    && seq_reg == 2'h0 && mode_reg == MODE_I2C_MASTER;
    assign in_ack = seq_reg == 2'h1;
    assign in_stp = seq_reg == 2'h2;
    assign tper   = {1'h0, div_reg, 1'h0} + 10'h002;
    // Counts are measured from the last wire event; the window allows
    // for the load cycle and the registered timeout tick.
    assign win    = cnt_reg + 10'h002 >= tper && cnt_reg <= tper + 10'h003;

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            mode_reg <= MODE_RESET;
            div_reg  <= BAUD_RESET;
        end else begin
            if (ctl_wr)
                mode_reg <= WDATA[3:0];
            if (CE && WR && ADDR == OFS_BAUD)
                div_reg <= WDATA;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            seq_reg <= 2'h0;
            rel_reg <= 1'h0;
        end else if (ack_go) begin
            seq_reg <= 2'h1;
        end else if (stp_go) begin
            seq_reg <= 2'h2;
        end else if (in_ack && rel_reg && $fell(SCL_OE_B)) begin
            seq_reg <= 2'h0;
            rel_reg <= 1'h0;
        end else if (in_ack && $rose(SCL_OE_B)) begin
            rel_reg <= 1'h1;
        end else if (in_stp && $rose(SDA_OE_B)) begin
            seq_reg <= 2'h0;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            go_reg  <= 1'h0;
            cnt_reg <= 10'h000;
        end else begin
            go_reg <= ack_go || stp_go;
            if (go_reg || $changed(SCL_OE_B) || $changed(SDA_OE_B)
                || $changed(SCL_IN) || $changed(SDA_IN))
                cnt_reg <= 10'h000;
            else if (cnt_reg != 10'h3FF)
                cnt_reg <= cnt_reg + 10'h001;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    a_ack_drive: assert property (
        ack_go |=> !SCL_OE_B && SDA_OE_B == $past(WDATA[CTL_ACK_DATA]))
        else $error("ack start did not drive the lines");
    a_ack_release: assert property (
        in_ack && !rel_reg && $rose(SCL_OE_B) |-> win)
        else $error("ack released SCL at the wrong time");
    a_ack_arbit: assert property (
        in_ack && rel_reg && !SCL_IN && !$past(SCL_IN) |-> SCL_OE_B)
        else $error("ack pulled SCL while it was stretched");
    a_ack_finish: assert property (
        in_ack && rel_reg && $fell(SCL_OE_B) |-> win && SDA_OE_B
        ##1 !SCL_OE_B [*4])
        else $error("ack end timing or lines wrong");
    a_stop_drive: assert property (
        stp_go |=> !SDA_OE_B && !SCL_OE_B)
        else $error("stop start did not pull SDA low");
    a_stop_scl: assert property (
        in_stp && $rose(SCL_OE_B) |-> win && !SDA_OE_B)
        else $error("stop released SCL at the wrong time");
    a_stop_sda: assert property (
        in_stp && $rose(SDA_OE_B) |-> win && SCL_OE_B)
        else $error("stop released SDA at the wrong time");
    a_ninth_hold: assert property (
        NINTH_FALL && CE && mode_reg == MODE_I2C_MASTER && seq_reg == 2'h0
        |=> !SCL_OE_B [*3])
        else $error("SCL not held low after the ninth clock");
    a_open_drain: assert property (
        !SCL_OUT && !SDA_OUT)
        else $error("open drain output driven high");
    a_rdata_quiet: assert property (
        !$past(RD) |-> RDATA == 8'h00)
        else $error("read data present without a read");
endmodule

bind iam_sequencer iam_seq_props props_u (
    .CORE_CLK(CORE_CLK), .RST_B(RST_B), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .NINTH_FALL(NINTH_FALL), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT),
    .SCL_OE_B(SCL_OE_B), .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT),
    .SDA_OE_B(SDA_OE_B), .SHIFT_BUFFER(SHIFT_BUFFER)
);

// [verif/i2c_master_ack_stop_sequencer_tb.sv]
// Self-checking bench of the acknowledge and stop sequencer.
`timescale 1ns/100ps
module i2c_master_ack_stop_sequencer_tb
    import iam_pkg::*;
;
    logic              core_clk = 1'h0;
    logic              rst_b = 1'h0;
    logic              ce = 1'h1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr_stb = 1'h0;
    logic              rd_stb = 1'h0;
    logic              ninth = 1'h0;
    logic [3:0]        stretch = 4'h0;
    logic [DATA_W-1:0] rdata, shift_buf;
    logic              scl_in, scl_out, scl_oe_b;
    logic              sda_in, sda_out, sda_oe_b;
    logic [DATA_W-1:0] exp_q[$];
    logic              rd_prev = 1'h0;
    logic [31:0]       seed = 32'h5793;
    int                fails = 0;
    int                checks_done = 0;

    iam_sequencer dut_u (
        .CORE_CLK(core_clk), .RST_B(rst_b), .CE(ce), .ADDR(addr),
        .WDATA(wdata), .WR(wr_stb), .RD(rd_stb), .RDATA(rdata),
        .NINTH_FALL(ninth), .SCL_IN(scl_in), .SCL_OUT(scl_out),
        .SCL_OE_B(scl_oe_b), .SDA_IN(sda_in), .SDA_OUT(sda_out),
        .SDA_OE_B(sda_oe_b), .SHIFT_BUFFER(shift_buf)
    );

    iam_slave_model slave_u (
        .clk(core_clk), .rst_b(rst_b), .scl_oe_b(scl_oe_b),
        .sda_oe_b(sda_oe_b), .stretch(stretch), .scl_wire(scl_in),
        .sda_wire(sda_in)
    );

    always #5 core_clk = ~core_clk;

    // ********
    // Bus tasks and result checking
    // ********
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %0t read %h expected %h", $time, seen, want);
        end
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'h1;
        @(posedge core_clk);
        wr_stb <= 1'h0;
    endtask

    // The expected value is queued before the strobe goes out.
    task automatic reg_rd(input logic [1:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        @(posedge core_clk);
        addr   <= a;
        rd_stb <= 1'h1;
        @(posedge core_clk);
        rd_stb <= 1'h0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Bounded wait, so a stuck sequence cannot hang the run.
    task automatic wait_oe(input logic sda, input logic v);
        int i;
        i = 0;
        while (((sda ? sda_oe_b : scl_oe_b) !== v) && i < 400) begin
            @(posedge core_clk);
            i++;
        end
        if (i == 400) begin
            fails++;
            $display("ERROR %0t line wait ran out", $time);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(negedge core_clk) begin
        if (rd_prev)
            check(rdata, exp_q.pop_front());
        rd_prev = rd_stb;
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        fails++;
        $display("ERROR %0t run did not finish", $time);
        test_done;
    end

    initial begin
        int         d;
        logic       ack;
        logic [7:0] b;
        wt(2);
        rst_b <= 1'h1;
        reg_rd(OFS_STATUS, 8'h08);
        reg_rd(OFS_CONTROL, 8'h00);
        reg_rd(OFS_BAUD, BAUD_RESET);
        reg_rd(OFS_BUFFER, BUFFER_RESET);
        reg_wr(OFS_CONTROL, 8'h27);
        reg_rd(OFS_CONTROL, 8'h07);
        b = 8'(xs());
        reg_wr(OFS_BUFFER, b);
        reg_rd(OFS_BUFFER, b);
        reg_wr(OFS_CONTROL, 8'h08);
        ninth <= 1'h1;
        @(posedge core_clk);
        ninth <= 1'h0;
        for (int k = 0; k < 4; k++) begin
            d = 2 + int'(xs() % 32'h4);
            ack = k[0];
            stretch <= k[1] ? 4'h5 : 4'h0;
            reg_wr(OFS_BAUD, 8'(d));
            reg_rd(OFS_BAUD, 8'(d));
            reg_wr(OFS_CONTROL, {2'h0, 1'h1, ack, 4'h8});
            reg_wr(OFS_BUFFER, ~b);
            reg_rd(OFS_CONTROL, {2'h0, 1'h1, ack, 4'h8});
            wait_oe(1'h0, 1'h1);
            wait_oe(1'h0, 1'h0);
            wt(2);
            reg_rd(OFS_CONTROL, {3'h0, ack, 4'h8});
            reg_rd(OFS_STATUS, 8'h0A);
            reg_rd(OFS_BUFFER, b);
            check(shift_buf, b);
            reg_wr(OFS_STATUS, 8'h02);
            reg_rd(OFS_STATUS, 8'h08);
        end
        // Stretching is off here: the stop checks SCL only after releasing SDA.
        stretch <= 4'h0;
        reg_wr(OFS_CONTROL, 8'h48);
        reg_wr(OFS_BUFFER, ~b);
        reg_rd(OFS_CONTROL, 8'h48);
        wait_oe(1'h1, 1'h1);
        wt(2 * (d + 1) + 6);
        reg_rd(OFS_STATUS, 8'h0F);
        reg_rd(OFS_CONTROL, 8'h08);
        reg_rd(OFS_BUFFER, b);
        reg_wr(OFS_STATUS, 8'h07);
        reg_rd(OFS_STATUS, 8'h08);
        wt(2);
        test_done;
    end
endmodule
